// ### btb_tx_buf.sv
// Transmit ping-pong payload buffers and packet type choice per TX slot.
// Assumes slot, response and load strobes come from logic on i_clk.
//
// How it works
// - One data pair per slave; one voice pair shared by the voice link.
// - Each buffer is two registers: composer reads current, loader fills next.
// - Load pointer is always the inverse of the read pointer.
// - Control packets common to both links carry a data-buffer style payload.
// - Mixed packet takes voice from voice pair, data from data pair.
// - Pure data uses medium- or high-rate types with length in header.
// - Without data, send NULL when ack or stop information pends.
// - Without data or link control information, send nothing.
// - Manager loads next register, then flush swaps both pointers.
// - At slot, composer reads current register and emits the packet.
// - Result comes from response; only an outstanding packet is judged.
// - ACK advances data selector; NAK holds it for retransmission.
// - After ACK with empty next, a flush selects newly loaded data.
// - Flush advances the selector regardless of ACK, dropping stale data.
// - Voice link uses HV; voice port keeps loading the next register.
// - Each voice slot reads current voice register, then toggles selector.
// - High-priority control in a voice slot replaces voice with DM packet.
// - Mixed packet toggles voice selector; data selector moves on ACK.
// - Mixed link falls back to HV when no data pends.
// - STOP sends default packets and freezes data; GO or silence resumes.
// - STOP stalls only the data buffer of the slave that sent it.
module btb_tx_buf (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_load,
  input wire logic [btb_pkg::SW-1:0] i_load_slave,
  input wire btb_pkg::btb_pld_s i_load_pld,
  input wire logic i_flush,
  input wire logic [btb_pkg::SW-1:0] i_flush_slave,
  input wire logic i_voice_load,
  input wire logic [btb_pkg::VW-1:0] i_voice_word,
  input wire logic i_sco_on,
  input wire logic [btb_pkg::SW-1:0] i_sco_slave,
  input wire logic [btb_pkg::IW-1:0] i_voice_slot_interval,
  input wire logic i_slot,
  input wire logic [btb_pkg::SW-1:0] i_slot_slave,
  input wire logic i_link_good,
  input wire logic i_lc_info,
  input wire logic i_ctrl_req,
  input wire btb_pkg::btb_pld_s i_ctrl_pld,
  input wire logic i_resp,
  input wire logic [btb_pkg::SW-1:0] i_resp_slave,
  input wire logic i_resp_rx,
  input wire logic i_resp_ack,
  input wire logic i_resp_stop,
  output btb_pkg::btb_pkt_s o_pkt,
  output logic o_pkt_valid,
  output logic [btb_pkg::NSLV-1:0] o_stalled
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  btb_pkg::btb_pld_s data_reg_q [btb_pkg::NSLV][2];
  logic [1:0] data_full_q [btb_pkg::NSLV];
  logic [btb_pkg::NSLV-1:0] data_read_pointer_q; // Selector, read half
  logic [btb_pkg::NSLV-1:0] out_q;                // Packet awaiting result
  logic [btb_pkg::NSLV-1:0] stop_q;
  logic [btb_pkg::VW-1:0] voice_reg_q [2];
  logic voice_buffer_selector_q;
  logic [btb_pkg::IW-1:0] vcnt_q;
  btb_pkg::btb_pkt_s pkt_d;
  btb_pkg::btb_pkt_s pkt_q;
  logic pkt_valid_q;
  logic voice_slot;
  logic data_sent;
  logic ack_hit;

  // Load half of a selector is the other register by construction
  function automatic logic load_ptr(input logic rd);
    load_ptr = ~rd;
  endfunction : load_ptr

  // Data waiting in the current register and not frozen by STOP
  function automatic logic pending(input logic [btb_pkg::SW-1:0] s,
                                   input logic [1:0] full,
                                   input logic rd,
                                   input logic stp);
    pending = full[rd] & ~stp;
  endfunction : pending

  // ----------------------------------------------------------------
  // Data pairs
  // ----------------------------------------------------------------
  // Loads land on the next register, so a load never races the composer
  always_ff @(posedge i_clk) begin
    if (i_load) begin
      data_reg_q[i_load_slave][load_ptr(data_read_pointer_q[i_load_slave])] <= i_load_pld;
    end
  end

  // Result only counts for a packet that really carried buffered data
  assign ack_hit = i_resp & i_resp_rx & i_resp_ack & out_q[i_resp_slave];

  // Full flags: load sets next, ACK or flush clears current; set wins
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int s = 0; s < btb_pkg::NSLV; s++) begin
        data_full_q[s] <= 2'h0;
      end
    end else begin
      for (int s = 0; s < btb_pkg::NSLV; s++) begin
        // Clear and set address different bits, so a load with a flush survives
        if ((ack_hit && i_resp_slave == s[btb_pkg::SW-1:0]) ||
            (i_flush && i_flush_slave == s[btb_pkg::SW-1:0])) begin
          data_full_q[s][data_read_pointer_q[s]] <= 1'b0;
        end
        if (i_load && i_load_slave == s[btb_pkg::SW-1:0]) begin
          data_full_q[s][load_ptr(data_read_pointer_q[s])] <= 1'b1;
        end
      end
    end
  end

  // Both halves move as one; a NAK leaves the selector alone
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      data_read_pointer_q <= {btb_pkg::NSLV{btb_pkg::RST_SEL}};
    end else begin
      for (int s = 0; s < btb_pkg::NSLV; s++) begin
        if ((i_flush && i_flush_slave == s[btb_pkg::SW-1:0]) ||
            (ack_hit && i_resp_slave == s[btb_pkg::SW-1:0])) begin
          data_read_pointer_q[s] <= ~data_read_pointer_q[s];
        end
      end
    end
  end

  // Outstanding marker: set on a data-bearing send, cleared by any result
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      out_q <= '0;
    end else begin
      for (int s = 0; s < btb_pkg::NSLV; s++) begin
        if (i_resp && i_resp_slave == s[btb_pkg::SW-1:0]) begin
          out_q[s] <= 1'b0;
        end
        if (i_flush && i_flush_slave == s[btb_pkg::SW-1:0]) begin
          out_q[s] <= 1'b0;
        end
        if (data_sent && i_slot_slave == s[btb_pkg::SW-1:0]) begin
          out_q[s] <= 1'b1;
        end
      end
    end
  end

  // Flow state per slave; no packet received counts as GO
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      stop_q <= '0;
    end else if (i_resp) begin
      stop_q[i_resp_slave] <= i_resp_rx & i_resp_stop;
    end
  end

  // ----------------------------------------------------------------
  // Voice pair
  // ----------------------------------------------------------------
  // The port writes next at any time; it never sees the current register
  always_ff @(posedge i_clk) begin
    if (i_voice_load) begin
      voice_reg_q[~voice_buffer_selector_q] <= i_voice_word;
    end
  end

  // Slot counter; a zero interval wraps, giving one voice slot in every 256 slots
  assign voice_slot = i_slot & i_sco_on & (i_slot_slave == i_sco_slave) &
                      (vcnt_q == btb_pkg::RST_VCNT);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_sco_on) begin
      vcnt_q <= btb_pkg::RST_VCNT;
    end else if (i_slot) begin
      if (vcnt_q == btb_pkg::RST_VCNT) begin
        vcnt_q <= i_voice_slot_interval - 8'h01;
      end else begin
        vcnt_q <= vcnt_q - 8'h01;
      end
    end
  end

  // Toggles even when control traffic took the slot, keeping cadence
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      voice_buffer_selector_q <= btb_pkg::RST_SEL;
    end else if (voice_slot) begin
      voice_buffer_selector_q <= ~voice_buffer_selector_q;
    end
  end

  // ----------------------------------------------------------------
  // Composer
  // ----------------------------------------------------------------
  // Packet type choice from data, flow, voice cadence and link quality
  always_comb begin
    logic pend;
    pend = pending(i_slot_slave, data_full_q[i_slot_slave],
                   data_read_pointer_q[i_slot_slave], stop_q[i_slot_slave]);
    pkt_d.slave = i_slot_slave;
    pkt_d.data = data_reg_q[i_slot_slave][data_read_pointer_q[i_slot_slave]];
    pkt_d.voice = voice_reg_q[voice_buffer_selector_q];
    pkt_d.kind = btb_pkg::BTB_PK_NONE;
    data_sent = 1'b0;
    if (voice_slot) begin
      if (i_ctrl_req) begin
        pkt_d.kind = btb_pkg::BTB_PK_DM;
        pkt_d.data = i_ctrl_pld;
      end else if (pend) begin
        pkt_d.kind = btb_pkg::BTB_PK_DV;
        data_sent = 1'b1;
      end else begin
        pkt_d.kind = btb_pkg::BTB_PK_HV;
      end
    end else if (pend) begin
      pkt_d.kind = i_link_good ? btb_pkg::BTB_PK_DH : btb_pkg::BTB_PK_DM;
      data_sent = 1'b1;
    end else if (i_lc_info) begin
      pkt_d.kind = btb_pkg::BTB_PK_NULL;
    end
    data_sent = data_sent & i_slot;
  end

  // Registered hand-off; a NONE slot leaves valid low
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pkt_q <= '0;
      pkt_valid_q <= 1'b0;
    end else begin
      pkt_valid_q <= i_slot && pkt_d.kind != btb_pkg::BTB_PK_NONE;
      if (i_slot) begin
        pkt_q <= pkt_d;
      end
    end
  end

  // Outputs come straight from registers
  assign o_pkt = pkt_q;
  assign o_pkt_valid = pkt_valid_q;
  assign o_stalled = stop_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // A load with the selector at rest must leave the current register as it was
  sel_apart_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_load && !i_flush && !i_resp &&
    data_full_q[i_load_slave][data_read_pointer_q[i_load_slave]] |=>
    data_reg_q[$past(i_load_slave)][data_read_pointer_q[$past(i_load_slave)]] ==
    $past(data_reg_q[i_load_slave][data_read_pointer_q[i_load_slave]]))
    else $error("load reached the current register");

  flush_moves_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_flush && !(ack_hit && i_resp_slave == i_flush_slave) |=>
    data_read_pointer_q[$past(i_flush_slave)] !=
    $past(data_read_pointer_q[i_flush_slave]))
    else $error("flush did not advance selector");

  nak_holds_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_resp && !(i_resp_rx && i_resp_ack) && !i_flush |=> $stable(data_read_pointer_q))
    else $error("selector moved on NAK");

  ack_moves_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ack_hit && !i_flush |=>
    data_read_pointer_q[$past(i_resp_slave)] !=
    $past(data_read_pointer_q[i_resp_slave]))
    else $error("selector held on ACK");

  stop_quiet_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_slot && stop_q[i_slot_slave] && !voice_slot |=>
    o_pkt.kind inside {btb_pkg::BTB_PK_NULL, btb_pkg::BTB_PK_NONE})
    else $error("data sent while stopped");

  voice_toggle_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    voice_slot |=> voice_buffer_selector_q != $past(voice_buffer_selector_q))
    else $error("voice selector did not toggle");

  ctrl_wins_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    voice_slot && i_ctrl_req |=> o_pkt_valid && o_pkt.kind == btb_pkg::BTB_PK_DM)
    else $error("control did not take voice slot");

  hv_fallback_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    voice_slot && !i_ctrl_req && !data_full_q[i_slot_slave][data_read_pointer_q[i_slot_slave]]
    |=> o_pkt.kind == btb_pkg::BTB_PK_HV)
    else $error("no fallback to voice-only packet");

  idle_none_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_slot && !voice_slot && !i_lc_info &&
    !data_full_q[i_slot_slave][data_read_pointer_q[i_slot_slave]] |=> !o_pkt_valid)
    else $error("packet sent with nothing to send");

  type_quality_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_pkt_valid && o_pkt.kind == btb_pkg::BTB_PK_DH |-> $past(i_link_good))
    else $error("high-rate type on poor link");

endmodule : btb_tx_buf

// ### btb_pkg.sv
// Shared types and constants for the transmit payload buffering block.
// Assumes one slot-timing domain; every user of it names btb_pkg:: in full.
package btb_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NSLV = 2;          // Slaves served by the master
  localparam int SW = 1;            // Slave index width
  localparam int DW = 32;           // Payload word width
  localparam int LW = 8;            // Payload header length width
  localparam int VW = 16;           // Voice word width
  localparam int IW = 8;            // Voice interval width, in slots

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_SEL = 1'b0;
  localparam logic [IW-1:0] RST_VCNT = 8'h00;

  // ----------------------------------------------------------------
  // Packet types at the composer output
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BTB_PK_NONE = 3'h0,
    BTB_PK_NULL = 3'h1,
    BTB_PK_DM = 3'h3,
    BTB_PK_DH = 3'h2,
    BTB_PK_HV = 3'h6,
    BTB_PK_DV = 3'h7
  } btb_pkt_e;

  // Data payload with its payload-header length
  typedef struct packed {
    logic [LW-1:0] len;
    logic [DW-1:0] word;
  } btb_pld_s;

  // One composed packet handed to the bit processing
  typedef struct packed {
    btb_pkt_e kind;
    logic [SW-1:0] slave;
    btb_pld_s data;
    logic [VW-1:0] voice;
  } btb_pkt_s;

endpackage : btb_pkg

// ### btb_peer_model.sv
// Remote peer model: answers every sent packet with a result.
// Assumes it watches o_pkt and o_pkt_valid of btb_tx_buf on one clock.
module btb_peer_model (
  input wire logic i_clk,
  input wire logic i_pkt_valid,
  input wire btb_pkg::btb_pkt_s i_pkt,
  input wire logic i_rx_en,
  input wire logic i_ack_en,
  input wire logic i_stop_en,
  output logic o_resp,
  output logic [btb_pkg::SW-1:0] o_resp_slave,
  output logic o_rx,
  output logic o_ack,
  output logic o_stop
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pend = 1'b0;
  logic [btb_pkg::SW-1:0] slv = '0;
  // Idle values before the first packet
  initial begin
    o_resp = 1'b0;
    o_resp_slave = '0;
    o_rx = 1'b0;
    o_ack = 1'b0;
    o_stop = 1'b0;
  end
  // Result in the receive slot after each packet; idle fields churn
  always @(posedge i_clk) begin
    #2;
    o_resp = pend;
    if (pend) begin
      o_resp_slave = slv;
      o_rx = i_rx_en;
      o_ack = i_ack_en;
      o_stop = i_stop_en;
    end else begin
      o_resp_slave = ~o_resp_slave;
      o_rx = ~o_rx;
      o_ack = ~o_ack;
      o_stop = ~o_stop;
    end
    pend = i_pkt_valid;
    slv = i_pkt.slave;
  end
endmodule : btb_peer_model

// ### tb_top.sv
// Self-checking bench for btb_tx_buf with the remote peer model.
// Assumes one 200 MHz clock; the bench plays the manager and voice port.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_load = 0, i_flush = 0, i_voice_load = 0, i_sco_on = 0, i_slot = 0;
  logic [btb_pkg::SW-1:0] i_load_slave = '0, i_flush_slave = '0;
  logic [btb_pkg::SW-1:0] i_sco_slave = '0, i_slot_slave = '0, i_resp_slave;
  btb_pkg::btb_pld_s i_load_pld = '0, i_ctrl_pld = '0;
  logic [btb_pkg::VW-1:0] i_voice_word = '0;
  logic [btb_pkg::IW-1:0] i_voice_slot_interval = 8'h01;
  logic i_link_good = 1, i_lc_info = 0, i_ctrl_req = 0;
  logic i_resp, i_resp_rx, i_resp_ack, i_resp_stop;
  logic rx_en = 1, ack_en = 1, stop_en = 0;
  btb_pkg::btb_pkt_s o_pkt;
  logic o_pkt_valid;
  logic [btb_pkg::NSLV-1:0] o_stalled;
  int num_errors = 0;
  int n_checks = 0;
  // Free-running clock
  always #2.5 i_clk = ~i_clk;
  btb_tx_buf u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_load(i_load),
    .i_load_slave(i_load_slave), .i_load_pld(i_load_pld), .i_flush(i_flush),
    .i_flush_slave(i_flush_slave), .i_voice_load(i_voice_load),
    .i_voice_word(i_voice_word), .i_sco_on(i_sco_on), .i_sco_slave(i_sco_slave),
    .i_voice_slot_interval(i_voice_slot_interval), .i_slot(i_slot),
    .i_slot_slave(i_slot_slave), .i_link_good(i_link_good), .i_lc_info(i_lc_info),
    .i_ctrl_req(i_ctrl_req), .i_ctrl_pld(i_ctrl_pld), .i_resp(i_resp),
    .i_resp_slave(i_resp_slave), .i_resp_rx(i_resp_rx), .i_resp_ack(i_resp_ack),
    .i_resp_stop(i_resp_stop), .o_pkt(o_pkt), .o_pkt_valid(o_pkt_valid),
    .o_stalled(o_stalled));
  btb_peer_model u_peer (.i_clk(i_clk), .i_pkt_valid(o_pkt_valid), .i_pkt(o_pkt),
    .i_rx_en(rx_en), .i_ack_en(ack_en), .i_stop_en(stop_en), .o_resp(i_resp),
    .o_resp_slave(i_resp_slave), .o_rx(i_resp_rx), .o_ack(i_resp_ack),
    .o_stop(i_resp_stop));
  // ------------------------------------------------------------
  // Drivers and compares
  // ------------------------------------------------------------
  task automatic give_verdict();
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic bad(input string m);
    num_errors++;
    $display("BAD %0t %s", $time, m);
  endtask : bad
  // Inputs move 1 ns after the edge, away from sampling
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  // Load into the next register, then flush to make it current
  task automatic send(input logic [btb_pkg::SW-1:0] s, input btb_pkg::btb_pld_s p);
    i_load = 1;
    i_load_slave = s;
    i_load_pld = p;
    tick();
    i_load = 0;
    i_flush = 1;
    i_flush_slave = s;
    tick();
    i_flush = 0;
  endtask : send
  task automatic vload(input logic [btb_pkg::VW-1:0] w);
    i_voice_load = 1;
    i_voice_word = w;
    tick();
    i_voice_load = 0;
  endtask : vload
  // Bounded wait for the peer result to be taken
  task automatic wait_resp();
    int i;
    for (i = 0; i < 8; i++) begin
      @(posedge i_clk);
      if (i_resp === 1'b1) break;
    end
    #1;
    if (i == 8) bad("no response");
  endtask : wait_resp
  // One slot: compare kind, valid and optionally data
  task automatic tx(input logic [btb_pkg::SW-1:0] s, input btb_pkg::btb_pkt_e k,
                    input logic v, input btb_pkg::btb_pld_s d, input logic cd);
    i_slot = 1;
    i_slot_slave = s;
    tick();
    i_slot = 0;
    n_checks++;
    if (o_pkt_valid !== v || (v && (o_pkt.kind !== k || o_pkt.slave !== s ||
        (cd && o_pkt.data !== d))))
      bad("packet");
    if (v) wait_resp();
  endtask : tx
  task automatic chk_stall(input logic [btb_pkg::NSLV-1:0] e);
    n_checks++;
    if (o_stalled !== e) bad("stall state");
  endtask : chk_stall
  task automatic chk_voice(input logic [btb_pkg::VW-1:0] w);
    n_checks++;
    if (o_pkt.voice !== w) bad("voice word");
  endtask : chk_voice
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_data();
    ack_en = 0;
    send(0, 40'h04_1111_0001);
    tx(0, btb_pkg::BTB_PK_DH, 1, 40'h04_1111_0001, 1);
    i_link_good = 0;
    ack_en = 1;
    tx(0, btb_pkg::BTB_PK_DM, 1, 40'h04_1111_0001, 1);
    i_lc_info = 1;
    tx(0, btb_pkg::BTB_PK_NULL, 1, '0, 0);
    i_lc_info = 0;
    tx(0, btb_pkg::BTB_PK_NONE, 0, '0, 0);
    send(0, 40'h10_2222_0002);
    tx(0, btb_pkg::BTB_PK_DM, 1, 40'h10_2222_0002, 1);
  endtask : t_data
  // Flush while a payload is still unacknowledged drops it
  task automatic t_flush();
    ack_en = 0;
    send(0, 40'h01_3333_0003);
    tx(0, btb_pkg::BTB_PK_DM, 1, 40'h01_3333_0003, 1);
    send(0, 40'hFF_4444_0004);
    ack_en = 1;
    tx(0, btb_pkg::BTB_PK_DM, 1, 40'hFF_4444_0004, 1);
  endtask : t_flush
  task automatic t_stop();
    i_lc_info = 1;
    i_link_good = 1;
    stop_en = 1;
    tx(0, btb_pkg::BTB_PK_NULL, 1, '0, 0);
    chk_stall(2'h1);
    send(0, 40'h08_5555_0005);
    tx(0, btb_pkg::BTB_PK_NULL, 1, '0, 0);
    stop_en = 0;
    send(1, 40'h08_6666_0006);
    tx(1, btb_pkg::BTB_PK_DH, 1, 40'h08_6666_0006, 1);
    chk_stall(2'h1);
    rx_en = 0;
    tx(0, btb_pkg::BTB_PK_NULL, 1, '0, 0);
    chk_stall(2'h0);
    rx_en = 1;
    tx(0, btb_pkg::BTB_PK_DH, 1, 40'h08_5555_0005, 1);
  endtask : t_stop
  // Every slot is a voice slot with an interval of one
  task automatic t_voice();
    i_sco_on = 1;
    vload(16'hA001);
    tx(0, btb_pkg::BTB_PK_HV, 1, '0, 0);
    tx(0, btb_pkg::BTB_PK_HV, 1, '0, 0);
    chk_voice(16'hA001);
    vload(16'hB002);
    i_ctrl_req = 1;
    i_ctrl_pld = 40'h02_7777_0007;
    tx(0, btb_pkg::BTB_PK_DM, 1, 40'h02_7777_0007, 1);
    i_ctrl_req = 0;
    send(0, 40'h03_8888_0008);
    tx(0, btb_pkg::BTB_PK_DV, 1, 40'h03_8888_0008, 1);
    chk_voice(16'hB002);
    tx(0, btb_pkg::BTB_PK_HV, 1, '0, 0);
  endtask : t_voice
  // Interval of two: voice slots alternate with ordinary ones
  task automatic t_cadence();
    i_voice_slot_interval = 8'h02;
    vload(16'hC003);
    tx(0, btb_pkg::BTB_PK_HV, 1, '0, 0);
    tx(0, btb_pkg::BTB_PK_NULL, 1, '0, 0);
    tx(0, btb_pkg::BTB_PK_HV, 1, '0, 0);
    chk_voice(16'hC003);
  endtask : t_cadence
  // Main sequence after a 6-cycle reset
  initial begin
    tick(6);
    i_sys_rst = 1'b0;
    chk_stall(2'h0);
    t_data();
    t_flush();
    t_stop();
    t_voice();
    t_cadence();
    give_verdict();
  end
  // Watchdog well beyond the under a hundred cycles the scenarios need
  initial begin
    #20000;
    bad("timeout");
    give_verdict();
  end
endmodule : tb_top
